/* File: src/asfc_pkg.sv */
/*
 * package for the converter setup/filter configuration register bank:
 * register offsets, field positions, reset values and codes.
 * assumes a 32-bit ahb-lite slave with one register per aligned word.
 */
package asfc_pkg;

    // printed offsets are register indices; byte address is four times
    localparam logic [7:0]  IDX_SETUP2   = 8'h22;
    localparam logic [7:0]  IDX_SETUP3   = 8'h23;
    localparam logic [7:0]  IDX_FILTER0  = 8'h28;
    localparam logic [7:0]  IDX_STATUS   = 8'h30;
    localparam logic [9:0]  ADDR_SETUP2  = {IDX_SETUP2, 2'b00};
    localparam logic [9:0]  ADDR_SETUP3  = {IDX_SETUP3, 2'b00};
    localparam logic [9:0]  ADDR_FILTER0 = {IDX_FILTER0, 2'b00};
    localparam logic [9:0]  ADDR_STATUS  = {IDX_STATUS, 2'b00};
    localparam int          ADDR_W       = 10;

    // reset values
    localparam logic [15:0] SETUP_RESET  = 16'h1020;
    localparam logic [15:0] FILTER_RESET = 16'h0000;

    // writable bit masks; everything else is reserved and reads zero
    localparam logic [15:0] SETUP_WMASK  = 16'h1030;
    localparam logic [15:0] FILTER_WMASK = 16'h8F7F;
    localparam logic [15:0] DEC_WMASK    = 16'hFFFF;

    // setup field positions
    localparam int SETUP_CODING_BIT = 12;
    localparam int SETUP_REF_LO     = 4;

    // filter field positions
    localparam int FLT_DIRECT_BIT   = 15;
    localparam int FLT_MAINS_EN_BIT = 11;
    localparam int FLT_MAINS_LO     = 8;
    localparam int FLT_TYPE_LO      = 5;
    localparam int FLT_RATE_LO      = 0;

    // reference choices
    localparam logic [1:0] REF_EXTERNAL = 2'h0;
    localparam logic [1:0] REF_INTERNAL = 2'h2;
    localparam logic [1:0] REF_SUPPLY   = 2'h3;

    // filter types
    localparam logic [1:0] TYPE_SINC5_1 = 2'h0;
    localparam logic [1:0] TYPE_SINC3   = 2'h3;

    // post filter selections
    localparam logic [2:0] MAINS_27SPS  = 3'h2;
    localparam logic [2:0] MAINS_25SPS  = 3'h3;
    localparam logic [2:0] MAINS_20SPS  = 3'h5;
    localparam logic [2:0] MAINS_16SPS  = 3'h6;

    // direct decimation: word rate = modulator rate / (32 * value)
    localparam int          DEC_FACTOR    = 32;
    localparam logic [4:0]  DEC_SHIFT     = 5'h05;
    localparam logic [4:0]  RATE_FASTEST  = 5'h00;

    // ahb codes
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0]  HTRANS_SEQ    = 2'h3;

    // decoded configuration of one setup
    typedef struct packed {
        logic       offset_binary;
        logic [1:0] reference;
        logic       ref_valid;
    } asfc_setup_t;

    // decoded filter configuration
    typedef struct packed {
        logic        direct_mode;
        logic [14:0] decimation;
        logic [19:0] mod_divide;
        logic [1:0]  filter_type;
        logic        type_valid;
        logic [4:0]  rate_code;
        logic        mains_active;
        logic [2:0]  mains_select;
        logic        mains_valid;
    } asfc_filter_t;

    typedef enum logic [2:0] {
        RST_IDLE  = 3'b001,
        RST_ABORT = 3'b010,
        RST_START = 3'b100
    } asfc_restart_t;

endpackage

/* File: src/asfc_regs.sv */
/*
 * setup 2/3 and filter 0 configuration registers of a multiplexed
 * sigma-delta converter, reached over an ahb-lite slave port.
 * assumes one word per register, single whole-word transfers, and a
 * conversion sequencer outside that obeys the abort/restart pulses.
 */
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - setup bit 12 picks coding: 0 unipolar, 1 offset binary, resets 1
// - setup bits 5:4 pick reference: 00 external, 10 internal, 11 supply
// - reserved setup bits, and filter bits outside direct mode, read zero and ignore writes
// - any filter register write aborts conversion and restarts at first channel
// - filter bit 15 set makes bits 14:0 a direct sinc3 decimation value
// - direct mode rate is modulator rate over 32 times decimation value
// - bit 11 enables mains post filter, only effective with filter type 00
// - post filter codes 010, 011, 101, 110 give 27, 25, 20, 16.67 SPS
// - filter type 00 is sinc5 plus sinc1 default, 11 is sinc3
// - bits 4:0 pick output rate; 00000 fastest at 250 kSPS
module asfc_regs (
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic      [31:0]         hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    output asfc_pkg::asfc_setup_t    setup2_cfg,
    output asfc_pkg::asfc_setup_t    setup3_cfg,
    output asfc_pkg::asfc_filter_t   filter0_cfg,
    output logic                     conversion_abort,
    output logic                     sequence_restart
);

    logic [15:0]              setup2_q;
    logic [15:0]              setup3_q;
    logic [15:0]              filter0_q;
    logic                     wr_pend_q;
    logic [asfc_pkg::ADDR_W-1:0] addr_q;
    logic [31:0]              hrdata_q;
    asfc_pkg::asfc_restart_t  rst_state_q;
    asfc_pkg::asfc_restart_t  rst_state_d;
    logic [7:0]               restart_count_q;
    logic                     addr_phase;
    logic                     wr_commit;

    // read-back image of any byte address
    function automatic logic [31:0] read_value(
        input logic [asfc_pkg::ADDR_W-1:0] a,
        input logic [15:0]                 s2,
        input logic [15:0]                 s3,
        input logic [15:0]                 f0,
        input logic [7:0]                  cnt
    );
        logic [31:0] v;
        v = 32'h0000_0000;
        case (a)
            asfc_pkg::ADDR_SETUP2:  v = {16'h0000, s2};
            asfc_pkg::ADDR_SETUP3:  v = {16'h0000, s3};
            asfc_pkg::ADDR_FILTER0: v = {16'h0000, f0};
            asfc_pkg::ADDR_STATUS:  v = {24'h00_0000, cnt};
            default:                v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    // filter write: direct mode keeps all 15 value bits, else reserved forced low
    function automatic logic [15:0] filter_write(input logic [15:0] w);
        logic [15:0] m;
        m = w[asfc_pkg::FLT_DIRECT_BIT] ? asfc_pkg::DEC_WMASK : asfc_pkg::FILTER_WMASK;
        return w & m;
    endfunction

    // setup field decode, shared by both setups
    function automatic asfc_pkg::asfc_setup_t setup_decode(input logic [15:0] r);
        asfc_pkg::asfc_setup_t s;
        s.offset_binary = r[asfc_pkg::SETUP_CODING_BIT];
        s.reference     = r[asfc_pkg::SETUP_REF_LO +: 2];
        s.ref_valid     = (s.reference == asfc_pkg::REF_EXTERNAL) ||
                          (s.reference == asfc_pkg::REF_INTERNAL) ||
                          (s.reference == asfc_pkg::REF_SUPPLY);
        return s;
    endfunction

    // a valid transfer is taken whenever the bus is ready
    assign addr_phase = hsel && hready && (htrans == asfc_pkg::HTRANS_NONSEQ ||
                                           htrans == asfc_pkg::HTRANS_SEQ);
    assign wr_commit  = wr_pend_q;

    // zero-wait slave, always okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

    // address phase capture
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            addr_q    <= '0;
        end
        else
        begin
            wr_pend_q <= addr_phase && hwrite;
            if (addr_phase)
            begin
                addr_q <= haddr[asfc_pkg::ADDR_W-1:0];
            end
        end
    end

    // read data registered for the data phase of a read
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata_q <= 32'h0000_0000;
        end
        else if (addr_phase && !hwrite)
        begin
            hrdata_q <= read_value(haddr[asfc_pkg::ADDR_W-1:0], setup2_q, setup3_q,
                                   filter0_q, restart_count_q);
        end
    end

    // setup registers
    // masked writes, reset coding and reference
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            setup2_q <= asfc_pkg::SETUP_RESET;
            setup3_q <= asfc_pkg::SETUP_RESET;
        end
        else if (wr_commit)
        begin
            if (addr_q == asfc_pkg::ADDR_SETUP2)
            begin
                setup2_q <= hwdata[15:0] & asfc_pkg::SETUP_WMASK;
            end
            if (addr_q == asfc_pkg::ADDR_SETUP3)
            begin
                setup3_q <= hwdata[15:0] & asfc_pkg::SETUP_WMASK;
            end
        end
    end

    // filter register
    // reserved bits dropped unless direct mode
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            filter0_q <= asfc_pkg::FILTER_RESET;
        end
        else if (wr_commit && addr_q == asfc_pkg::ADDR_FILTER0)
        begin
            filter0_q <= filter_write(hwdata[15:0]);
        end
    end

    // restart sequencer: abort pulse, then restart pulse
    // every filter write, even same value, restarts
    always_comb
    begin
        rst_state_d = rst_state_q;
        case (rst_state_q)
            asfc_pkg::RST_IDLE:
                if (wr_commit && addr_q == asfc_pkg::ADDR_FILTER0)
                begin
                    rst_state_d = asfc_pkg::RST_ABORT;
                end
            asfc_pkg::RST_ABORT: rst_state_d = asfc_pkg::RST_START;
            asfc_pkg::RST_START:
                if (wr_commit && addr_q == asfc_pkg::ADDR_FILTER0)
                begin
                    rst_state_d = asfc_pkg::RST_ABORT;
                end
                else
                begin
                    rst_state_d = asfc_pkg::RST_IDLE;
                end
            default: rst_state_d = asfc_pkg::RST_IDLE;
        endcase
    end

    // a write landing during an abort is merged into that abort
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rst_state_q <= asfc_pkg::RST_IDLE;
        end
        else
        begin
            rst_state_q <= rst_state_d;
        end
    end

    assign conversion_abort = (rst_state_q == asfc_pkg::RST_ABORT);
    assign sequence_restart = (rst_state_q == asfc_pkg::RST_START);

    // wrapping count of restarts, visible to software
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            restart_count_q <= 8'h00;
        end
        else if (rst_state_q == asfc_pkg::RST_START)
        begin
            restart_count_q <= restart_count_q + 8'h01;
        end
    end

    // decoded setup outputs
    // coding and reference per setup
    assign setup2_cfg = setup_decode(setup2_q);
    assign setup3_cfg = setup_decode(setup3_q);

    // decoded filter outputs
    // direct mode overrides every other option
    always_comb
    begin
        filter0_cfg              = '0;
        filter0_cfg.direct_mode  = filter0_q[asfc_pkg::FLT_DIRECT_BIT];
        filter0_cfg.decimation   = filter0_q[14:0];
        // modulator divide ratio of 32 times value
        filter0_cfg.mod_divide   = {5'h00, filter0_q[14:0]} << asfc_pkg::DEC_SHIFT;
        if (!filter0_q[asfc_pkg::FLT_DIRECT_BIT])
        begin
            filter0_cfg.mod_divide   = 20'h0_0000;
            filter0_cfg.decimation   = 15'h0000;
            filter0_cfg.filter_type  = filter0_q[asfc_pkg::FLT_TYPE_LO +: 2];
            filter0_cfg.type_valid   = (filter0_cfg.filter_type == asfc_pkg::TYPE_SINC5_1) ||
                                       (filter0_cfg.filter_type == asfc_pkg::TYPE_SINC3);
            filter0_cfg.rate_code    = filter0_q[asfc_pkg::FLT_RATE_LO +: 5];
            filter0_cfg.mains_select = filter0_q[asfc_pkg::FLT_MAINS_LO +: 3];
            // only the four listed post filters are recognised
            filter0_cfg.mains_valid  = (filter0_cfg.mains_select == asfc_pkg::MAINS_27SPS) ||
                                       (filter0_cfg.mains_select == asfc_pkg::MAINS_25SPS) ||
                                       (filter0_cfg.mains_select == asfc_pkg::MAINS_20SPS) ||
                                       (filter0_cfg.mains_select == asfc_pkg::MAINS_16SPS);
            filter0_cfg.mains_active = filter0_q[asfc_pkg::FLT_MAINS_EN_BIT] &&
                                       (filter0_cfg.filter_type == asfc_pkg::TYPE_SINC5_1) &&
                                       filter0_cfg.mains_valid;
        end
    end

    // assertions
    sequence s_filter_write;
        wr_commit && addr_q == asfc_pkg::ADDR_FILTER0;
    endsequence

    sequence s_abort_then_restart;
        conversion_abort ##1 sequence_restart;
    endsequence

    // write yields abort then restart; one landing during an abort merges into it
    AST_FILTER_WRITE_RESTART: assert property (@(posedge hclk) disable iff (!hresetn)
        s_filter_write |=> (conversion_abort ##1 (sequence_restart || conversion_abort))
                           or (sequence_restart && $past(conversion_abort)))
        else $error("filter write did not abort and restart");

    // restart only ever follows an abort
    AST_RESTART_AFTER_ABORT: assert property (@(posedge hclk) disable iff (!hresetn)
        sequence_restart |-> $past(conversion_abort))
        else $error("restart without preceding abort");

    // restart count advances after the sequence
    AST_RESTART_COUNT: assert property (@(posedge hclk) disable iff (!hresetn)
        s_abort_then_restart |=> restart_count_q == $past(restart_count_q) + 8'h01)
        else $error("restart count did not advance");

    AST_PULSE_EXCLUSIVE: assert property (@(posedge hclk) disable iff (!hresetn)
        !(conversion_abort && sequence_restart))
        else $error("abort and restart high together");

    // writes elsewhere leave the conversion alone
    AST_SETUP_WRITE_NO_ABORT: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_commit && addr_q != asfc_pkg::ADDR_FILTER0 && rst_state_q == asfc_pkg::RST_IDLE
        |=> !conversion_abort)
        else $error("abort without filter write");

    AST_SETUP_RESERVED: assert property (@(posedge hclk) disable iff (!hresetn)
        ((setup2_q | setup3_q) & ~asfc_pkg::SETUP_WMASK) == 16'h0000)
        else $error("reserved setup bit set");

    // reserved filter bits zero outside direct mode
    AST_FILTER_RESERVED: assert property (@(posedge hclk) disable iff (!hresetn)
        !filter0_q[asfc_pkg::FLT_DIRECT_BIT] |-> (filter0_q & ~asfc_pkg::FILTER_WMASK) == 16'h0000)
        else $error("reserved filter bit set");

    AST_SETUP_CODING: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_commit && addr_q == asfc_pkg::ADDR_SETUP2)
        |=> setup2_cfg.offset_binary == $past(hwdata[asfc_pkg::SETUP_CODING_BIT]))
        else $error("setup coding not stored");

    AST_SETUP_REFERENCE: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_commit && addr_q == asfc_pkg::ADDR_SETUP3)
        |=> setup3_cfg.reference == $past(hwdata[asfc_pkg::SETUP_REF_LO +: 2]))
        else $error("setup reference not stored");

    AST_DIRECT_MODE: assert property (@(posedge hclk) disable iff (!hresetn)
        filter0_cfg.direct_mode |-> !filter0_cfg.mains_active && filter0_cfg.rate_code == 5'h00)
        else $error("options active in direct mode");

    // direct mode leaves no type or post filter recognised
    AST_DIRECT_CLEARS_TYPE: assert property (@(posedge hclk) disable iff (!hresetn)
        filter0_cfg.direct_mode |-> !filter0_cfg.type_valid && !filter0_cfg.mains_valid
                                    && filter0_cfg.filter_type == asfc_pkg::TYPE_SINC5_1)
        else $error("filter options decoded in direct mode");

    // divide ratio is 32 times value
    AST_DECIMATION_RATIO: assert property (@(posedge hclk) disable iff (!hresetn)
        filter0_cfg.direct_mode
        |-> filter0_cfg.mod_divide == 20'(filter0_q[14:0]) * 20'(asfc_pkg::DEC_FACTOR))
        else $error("decimation ratio wrong");

    AST_MAINS_NEEDS_TYPE: assert property (@(posedge hclk) disable iff (!hresetn)
        filter0_cfg.mains_active |-> filter0_q[asfc_pkg::FLT_TYPE_LO +: 2] == asfc_pkg::TYPE_SINC5_1
                                     && filter0_q[asfc_pkg::FLT_MAINS_EN_BIT])
        else $error("post filter active with wrong type");

    // reset default is sinc5+sinc1 at fastest rate
    AST_FILTER_RESET: assert property (@(posedge hclk)
        !hresetn |=> !hresetn || (filter0_cfg.filter_type == asfc_pkg::TYPE_SINC5_1 &&
                                  filter0_cfg.rate_code == asfc_pkg::RATE_FASTEST))
        else $error("filter reset default wrong");

endmodule

`default_nettype wire

/* File: dv/tb_top.sv */
/*
 * self-checking bench for asfc_regs: ahb-lite read/write tasks, then
 * sequences of calls comparing readback, decoded outputs and pulses.
 * assumes a single zero-wait slave whose hreadyout feeds hready.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic                   hclk;
    logic                   hresetn;
    logic                   hsel;
    logic [31:0]            haddr;
    logic [1:0]             htrans;
    logic                   hwrite;
    logic [2:0]             hsize;
    logic [31:0]            hwdata;
    logic                   hready;
    logic [31:0]            hrdata;
    logic                   hreadyout;
    logic                   hresp;
    asfc_pkg::asfc_setup_t  setup2_cfg;
    asfc_pkg::asfc_setup_t  setup3_cfg;
    asfc_pkg::asfc_setup_t  scfg;
    asfc_pkg::asfc_filter_t filter0_cfg;
    logic                   conversion_abort;
    logic                   sequence_restart;
    logic [31:0]            sa;
    logic [31:0]            sv;
    logic [15:0]            d;
    logic                   dm;
    logic                   ma;
    int                     miscompares;
    int                     n_tests;
    int                     restarts;

    // filter values: plain, reserved set, every post filter, direct mode edges
    localparam logic [15:0] FV [12] = '{16'h7dff, 16'h0a00, 16'h0b00, 16'h0d00, 16'h0e00, 16'h0200,
                                        16'h0a60, 16'h001f, 16'h8001, 16'hffff, 16'h8a65, 16'h0000};
    // setup values: all ones hits every reserved bit
    localparam logic [31:0] SV [5] = '{32'hffff_ffff, 32'h0000_0000, 32'h0000_1020, 32'h0000_0030,
                                       32'h0000_efcf};

    // single slave, so its ready is the bus ready
    assign hready = hreadyout;

    // 200 MHz clock
    initial hclk = 1'b0;
    always #2.5 hclk = ~hclk;

    asfc_regs dut (
        .hclk             (hclk),
        .hresetn          (hresetn),
        .hsel             (hsel),
        .haddr            (haddr),
        .htrans           (htrans),
        .hwrite           (hwrite),
        .hsize            (hsize),
        .hwdata           (hwdata),
        .hready           (hready),
        .hrdata           (hrdata),
        .hreadyout        (hreadyout),
        .hresp            (hresp),
        .setup2_cfg       (setup2_cfg),
        .setup3_cfg       (setup3_cfg),
        .filter0_cfg      (filter0_cfg),
        .conversion_abort (conversion_abort),
        .sequence_restart (sequence_restart)
    );

    // verdict and end of run, shared by the timeout paths
    task automatic stop_test();
        $display("compares %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // bounded wait for ready sampled high at a rising edge
    task automatic wait_ready();
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hready !== 1'b1 && n < 64);
        if (hready !== 1'b1)
        begin
            miscompares++;
            stop_test();
        end
    endtask

    // one single-word transfer; read data taken at the data phase edge
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= asfc_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        logic [31:0] x;
        bus(1'b1, a, v, x);
    endtask

    task automatic rchk(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, a, 32'h0000_0000, x);
        check(x, e);
        check(hresp, 1'b0);
    endtask

    // abort in the cycle after the write edge, restart one cycle later
    task automatic pulse_chk(input logic filt);
        #1;
        check(conversion_abort, filt);
        check(sequence_restart, 1'b0);
        @(posedge hclk);
        #1;
        check(conversion_abort, 1'b0);
        check(sequence_restart, filt);
        @(posedge hclk);
    endtask

    task automatic do_reset();
        hresetn <= 1'b0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
    endtask

    // reset values seen on the bus and on the decoded outputs
    task automatic reset_chk();
        rchk({22'h0, asfc_pkg::ADDR_SETUP2}, 32'h0000_1020);
        rchk({22'h0, asfc_pkg::ADDR_SETUP3}, 32'h0000_1020);
        rchk({22'h0, asfc_pkg::ADDR_FILTER0}, 32'h0000_0000);
        check(setup2_cfg.offset_binary, 1'b1);
        check(setup3_cfg.reference, asfc_pkg::REF_INTERNAL);
        check(filter0_cfg.filter_type, asfc_pkg::TYPE_SINC5_1);
        check(filter0_cfg.rate_code, asfc_pkg::RATE_FASTEST);
    endtask

    // hang guard at 400 us, far beyond the roughly 1 us run
    initial
    begin
        #400000;
        miscompares++;
        stop_test();
    end

    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        miscompares = 0;
        n_tests = 0;
        restarts = 0;
        do_reset();
        reset_chk();
        rchk({22'h0, asfc_pkg::ADDR_STATUS}, 32'h0000_0000);
        $display("test reset_values done");
        // both setups, reserved bits stripped, no abort from a setup write
        // internal reference enable sits in the mode register, outside this bank
        // setup values never use the unlisted reference code 01
        for (int s = 0; s < 2; s++)
        begin
            for (int k = 0; k < 5; k++)
            begin
                sa = s ? {22'h0, asfc_pkg::ADDR_SETUP3} : {22'h0, asfc_pkg::ADDR_SETUP2};
                sv = SV[k];
                wr(sa, sv);
                pulse_chk(1'b0);
                rchk(sa, sv & {16'h0, asfc_pkg::SETUP_WMASK});
                scfg = s ? setup3_cfg : setup2_cfg;
                check(scfg.offset_binary, sv[12]);
                check(scfg.reference, sv[5:4]);
                check(scfg.ref_valid, sv[5:4] != 2'b01);
            end
        end
        $display("test setup_regs done");
        // every filter write restarts; decode follows the stored word
        // a single filter register, so all enabled channels share type and rate
        // non-direct values use listed type and post filter codes, or the reset code
        for (int i = 0; i < 12; i++)
        begin
            d = FV[i];
            wr({22'h0, asfc_pkg::ADDR_FILTER0}, {16'h0, d});
            pulse_chk(1'b1);
            restarts++;
            rchk({22'h0, asfc_pkg::ADDR_FILTER0}, d[15] ? {16'h0, d} : {16'h0, d & 16'h0f7f});
            dm = d[15];
            ma = !dm && d[11] && d[6:5] == 2'b00 && d[10:8] inside {3'h2, 3'h3, 3'h5, 3'h6};
            check(filter0_cfg.direct_mode, dm);
            check(filter0_cfg.decimation, dm ? {17'h0, d[14:0]} : 32'h0000_0000);
            check(filter0_cfg.mod_divide, dm ? {12'h0, d[14:0], 5'h00} : 32'h0000_0000);
            check(filter0_cfg.filter_type, dm ? 2'b00 : d[6:5]);
            check(filter0_cfg.type_valid, !dm && d[6:5] inside {2'b00, 2'b11});
            check(filter0_cfg.rate_code, dm ? 5'h00 : d[4:0]);
            check(filter0_cfg.mains_active, ma);
            check(filter0_cfg.mains_valid, !dm && d[10:8] inside {3'h2, 3'h3, 3'h5, 3'h6});
            if (ma)
                check(filter0_cfg.mains_select, d[10:8]);
        end
        $display("test filter_reg done");
        // unmapped place reads zero, status ignores writes and counts restarts
        wr(32'h0000_0084, 32'hffff_ffff);
        pulse_chk(1'b0);
        rchk(32'h0000_0084, 32'h0000_0000);
        wr({22'h0, asfc_pkg::ADDR_STATUS}, 32'h0000_00ff);
        pulse_chk(1'b0);
        rchk({22'h0, asfc_pkg::ADDR_STATUS}, restarts & 32'h0000_00ff);
        $display("test unmapped_status done");
        // second reset in mid-run restores defaults and clears the restart count
        do_reset();
        reset_chk();
        rchk({22'h0, asfc_pkg::ADDR_STATUS}, 32'h0000_0000);
        $display("test second_reset done");
        stop_test();
    end
endmodule
`default_nettype wire
